/* File: src/sinc3_decimator_chop_ctrl.sv */
// Sinc3 decimator with chop control, settling suppression and Avalon-MM registers.
// Assumes an external modulator bit pin sampled asynchronously, word-addressed slave.
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`default_nettype none

module sinc3_decimator_chop_ctrl
  import sinc3_pkg::*;
#(
  parameter int unsigned MOD_TICK_P = MOD_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire avmm_req_t avmm_req,
  output logic [31:0] avmm_readdata,
  output logic avmm_waitrequest,
  // Modulator side
  input wire logic mod_bit,
  output logic input_swap,
  output logic [CHAN_W-1:0] channel_sel,
  // Result strobe
  output logic result_strobe
);

  typedef struct packed {
    logic [2:0] sync;
    logic mod_level;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic chop_dis;
    logic [CHAN_W-1:0] chan;
    logic [7:0] decim;
    logic waitrequest;
    logic [31:0] readdata;
    logic core_clear;
    chop_state_t cstate;
    logic swap;
    logic signed [ACC_W-1:0] prev;
    logic signed [ACC_W-1:0] result;
    logic ready;
    logic overrun;
    logic settled;
    logic strobe;
    logic [15:0] conv_count;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic core_valid;
  logic signed [ACC_W-1:0] core_value;
  logic [1:0] core_count;

  sinc3_core u_core (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sample_tick(st.tick),
    .sample_bit(st.mod_level),
    .clear(st.core_clear),
    .decim_word(st.decim),
    .out_valid(core_valid),
    .out_value(core_value),
    .out_count(core_count)
  );

  // Halve with sign kept; sum of two phases cannot overflow ACC_W
  function automatic logic signed [ACC_W-1:0] pair_mean(
    input logic signed [ACC_W-1:0] a,
    input logic signed [ACC_W-1:0] b
  );
    logic signed [ACC_W:0] s;
    s = {a[ACC_W-1], a} + {b[ACC_W-1], b};
    pair_mean = s[ACC_W:1];
  endfunction : pair_mean

  always_comb begin
    logic req_seen;
    logic req_done;
    logic data_read;
    logic deliver;
    logic signed [ACC_W-1:0] phase_val;
    logic signed [ACC_W-1:0] new_result;
    logic [7:0] min_word;
    req_seen = 1'b0;
    req_done = 1'b0;
    data_read = 1'b0;
    deliver = 1'b0;
    phase_val = '0;
    new_result = '0;
    min_word = '0;
    next_st = st;
    next_st.tick = 1'b0;
    next_st.core_clear = 1'b0;
    next_st.strobe = 1'b0;

    // Three-stage pin synchroniser; level accepted when stages two and three agree
    next_st.sync = {st.sync[1:0], mod_bit};
    if (st.sync[1] == st.sync[2]) begin
      next_st.mod_level = st.sync[2];
    end

    // Modulator sample rate from the system clock
    if (st.tick_cnt >= TICK_W'(MOD_TICK_P - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
    end

    // Bus: waitrequest high on the first cycle, low on the second
    req_seen = (avmm_req.read || avmm_req.write) && st.waitrequest;
    req_done = (avmm_req.read || avmm_req.write) && !st.waitrequest;
    next_st.waitrequest = !req_seen;

    if (req_seen && avmm_req.read) begin
      case (avmm_req.address)
        ADDR_CTRL: begin
          next_st.readdata = '0;
          next_st.readdata[CTRL_CHOP_DIS_BIT] = st.chop_dis;
          next_st.readdata[CTRL_CHAN_LSB +: CHAN_W] = st.chan;
        end
        ADDR_DECIM: begin
          next_st.readdata = {24'h00_0000, st.decim};
        end
        ADDR_STATUS: begin
          min_word = st.chop_dis ? DECIM_MIN_NOCHOP : DECIM_MIN_CHOP;
          next_st.readdata = '0;
          next_st.readdata[STAT_READY_BIT] = st.ready;
          next_st.readdata[STAT_SETTLED_BIT] = st.settled;
          next_st.readdata[STAT_OVERRUN_BIT] = st.overrun;
          // Flags a word below the minimum for the chop mode; software must keep it legal
          next_st.readdata[STAT_RANGE_BIT] = (st.decim < min_word);
          next_st.readdata[STAT_SWAP_BIT] = st.swap;
        end
        ADDR_DATA: begin
          next_st.readdata = st.result[DATA_LSB +: 32];
        end
        ADDR_COUNT: begin
          next_st.readdata = {16'h0000, st.conv_count};
        end
        default: begin
          next_st.readdata = '0;
        end
      endcase
    end

    data_read = req_done && avmm_req.read && (avmm_req.address == ADDR_DATA);

    if (req_done && avmm_req.write && avmm_req.byteenable[0]) begin
      case (avmm_req.address)
        ADDR_CTRL: begin
          next_st.chop_dis = avmm_req.writedata[CTRL_CHOP_DIS_BIT];
          next_st.chan = avmm_req.writedata[CTRL_CHAN_LSB +: CHAN_W];
          next_st.cstate = ST_RESTART;
        end
        ADDR_DECIM: begin
          next_st.decim = avmm_req.writedata[7:0];
          next_st.cstate = ST_RESTART;
        end
        default: begin
        end
      endcase
    end

    // Filter output handling
    if (st.cstate == ST_RESTART) begin
      next_st.core_clear = 1'b1;
      next_st.swap = 1'b0;
      next_st.settled = 1'b0;
      next_st.cstate = ST_FIRST;
    end else if (core_valid && !st.core_clear) begin
      if (st.chop_dis) begin
        // Free-running decimation; the first two results are suppressed, the third and later are delivered
        if (core_count == 2'(SETTLE_OUTPUTS)) begin
          deliver = 1'b1;
          new_result = core_value;
          next_st.settled = 1'b1;
          next_st.cstate = ST_RUN;
        end
      end else if (core_count == 2'(SETTLE_OUTPUTS)) begin
        // One chop phase is a full three-decimation window from cleared state
        phase_val = st.swap ? -core_value : core_value;
        next_st.prev = phase_val;
        next_st.swap = !st.swap;
        next_st.core_clear = 1'b1;
        if (st.cstate == ST_FIRST) begin
          // First phase after a change has no partner; hold it back
          next_st.cstate = ST_RUN;
        end else begin
          deliver = 1'b1;
          new_result = pair_mean(st.prev, phase_val);
          next_st.settled = 1'b1;
        end
      end
    end

    // Ready is sticky; a new result in the clearing cycle keeps it set
    if (data_read) begin
      next_st.ready = 1'b0;
      next_st.overrun = 1'b0;
    end
    if (deliver) begin
      next_st.result = new_result;
      next_st.strobe = 1'b1;
      next_st.overrun = st.ready && !data_read;
      next_st.ready = 1'b1;
      next_st.conv_count = st.conv_count + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.waitrequest <= 1'b1;
      st.decim <= DECIM_RESET;
      st.chop_dis <= CHOP_DIS_RESET;
      st.cstate <= ST_RESTART;
    end else begin
      st <= next_st;
    end
  end

  assign avmm_readdata = st.readdata;
  assign avmm_waitrequest = st.waitrequest;
  assign input_swap = st.swap;
  assign channel_sel = st.chan;
  assign result_strobe = st.strobe;

endmodule : sinc3_decimator_chop_ctrl

`default_nettype wire

/* File: src/sinc3_pkg.sv */
// Constants, register map and shared types for the sinc3 decimator.
// Assumes one 250 MHz system clock and a word-addressed Avalon-MM slave.
`default_nettype none

package sinc3_pkg;

  // Clock and modulator timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MOD_RATE_HZ = 32_768;  // 32.768 kHz
  // Truncated; 7629 cycles per sample fits the 16-bit tick counter
  localparam int unsigned MOD_TICK_CYCLES = CLK_HZ / MOD_RATE_HZ;
  localparam int TICK_W = 16;

  // Filter arithmetic
  localparam int ACC_W = 36;
  localparam int LEN_W = 11;
  localparam int DECIM_SHIFT = 3;      // Ratio is word times 8
  localparam int SETTLE_OUTPUTS = 3;   // Sinc3 needs three decimations to settle
  localparam int DATA_LSB = 3;

  // Register word addresses
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_DECIM = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_COUNT = 3'h4;

  // Field positions
  localparam int CTRL_CHOP_DIS_BIT = 0;
  localparam int CTRL_CHAN_LSB = 4;
  localparam int CHAN_W = 4;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_SETTLED_BIT = 1;
  localparam int STAT_OVERRUN_BIT = 2;
  localparam int STAT_RANGE_BIT = 3;
  localparam int STAT_SWAP_BIT = 4;

  // Reset values and limits
  localparam logic [7:0] DECIM_RESET = 8'h45;
  localparam logic CHOP_DIS_RESET = 1'b0;
  localparam logic [7:0] DECIM_MIN_NOCHOP = 8'h03;
  localparam logic [7:0] DECIM_MIN_CHOP = 8'h0d;

  typedef enum logic [1:0] {
    ST_RESTART = 2'b00,
    ST_FIRST = 2'b01,
    ST_RUN = 2'b10
  } chop_state_t;

  typedef struct packed {
    logic [2:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic signed [ACC_W-1:0] i1;
    logic signed [ACC_W-1:0] i2;
    logic signed [ACC_W-1:0] i3;
    logic signed [ACC_W-1:0] d1;
    logic signed [ACC_W-1:0] d2;
    logic signed [ACC_W-1:0] d3;
    logic [LEN_W-1:0] cnt;
    logic signed [ACC_W-1:0] out;
    logic valid;
    logic [1:0] nout;
  } core_state_t;

  function automatic logic [LEN_W-1:0] decim_last(input logic [7:0] word);
    decim_last = LEN_W'({word, 3'h0} - 11'h001);
  endfunction : decim_last

endpackage : sinc3_pkg

`default_nettype wire

/* File: src/sinc3_core.sv */
// Third-order sinc integrator/comb chain with a synchronous restart.
// Assumes sample_tick is a one-cycle pulse per modulator sample.
`default_nettype none

module sinc3_core
  import sinc3_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Sample stream
  input wire logic sample_tick,
  input wire logic sample_bit,
  input wire logic clear,
  input wire logic [7:0] decim_word,
  // Decimated output
  output logic out_valid,
  output logic signed [ACC_W-1:0] out_value,
  output logic [1:0] out_count
);

  core_state_t st;
  core_state_t next_st;

  always_comb begin
    logic signed [ACC_W-1:0] x;
    logic signed [ACC_W-1:0] c1;
    logic signed [ACC_W-1:0] c2;
    x = '0;
    c1 = '0;
    c2 = '0;
    next_st = st;
    next_st.valid = 1'b0;
    if (clear) begin
      // Clear wins over a coincident sample; costs one bit in 7629 cycles
      next_st = '0;
    end else if (sample_tick) begin
      x = sample_bit ? 36'sh0_0000_0001 : -36'sh0_0000_0001;
      next_st.i1 = st.i1 + x;
      next_st.i2 = st.i2 + next_st.i1;
      next_st.i3 = st.i3 + next_st.i2;
      if (st.cnt >= decim_last(decim_word)) begin
        // Decimate by word times eight
        next_st.cnt = '0;
        c1 = next_st.i3 - st.d1;
        c2 = c1 - st.d2;
        next_st.d1 = next_st.i3;
        next_st.d2 = c1;
        next_st.d3 = c2;
        next_st.out = c2 - st.d3;
        next_st.valid = 1'b1;
        if (st.nout != 2'(SETTLE_OUTPUTS)) begin
          next_st.nout = st.nout + 2'h1;
        end
      end else begin
        next_st.cnt = st.cnt + 11'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_valid = st.valid;
  assign out_value = st.out;
  assign out_count = st.nout;

endmodule : sinc3_core

`default_nettype wire

/* File: sim/sinc3_checker.sv */
// Port checker for the sinc3 decimator: bus timing, settling and rates.
// Assumes a write lands at the edge where waitrequest is sampled low.
`default_nettype none
module sinc3_checker
  import sinc3_pkg::*;
#(
  parameter int unsigned MOD_TICK_P = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register bus
  input wire avmm_req_t avmm_req,
  input wire logic avmm_waitrequest,
  // Outputs
  input wire logic input_swap,
  input wire logic [CHAN_W-1:0] channel_sel,
  input wire logic result_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TP = int'(MOD_TICK_P);
  logic rs, chop_dis, seen, sseen, sw_q, swchg;
  logic [7:0] dec;
  logic [CHAN_W-1:0] chan;
  int scnt, rcnt, wcnt, per, base;
  assign rs = avmm_req.write && !avmm_waitrequest && avmm_req.byteenable[0]
    && (avmm_req.address == ADDR_CTRL || avmm_req.address == ADDR_DECIM);
  assign swchg = input_swap != sw_q;
  assign per = (chop_dis ? 8 : 24) * int'(dec) * TP;
  // Chop on loses one sample to the restart clear
  assign base = chop_dis ? 3 * per : 2 * per + TP;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dec <= DECIM_RESET;
      chop_dis <= CHOP_DIS_RESET;
      chan <= '0;
      {seen, sseen, sw_q} <= '0;
      {scnt, rcnt, wcnt} <= '0;
    end else begin
      if (rs && avmm_req.address == ADDR_DECIM) dec <= avmm_req.writedata[7:0];
      if (rs && avmm_req.address == ADDR_CTRL) begin
        chop_dis <= avmm_req.writedata[CTRL_CHOP_DIS_BIT];
        chan <= avmm_req.writedata[CTRL_CHAN_LSB +: CHAN_W];
      end
      sw_q <= input_swap;
      scnt <= result_strobe ? 1 : scnt + 1;
      rcnt <= rs ? 1 : rcnt + 1;
      wcnt <= swchg ? 1 : wcnt + 1;
      seen <= !rs && (seen || result_strobe);
      // A swap reset right after restart is not a phase end
      sseen <= !rs && (sseen || (swchg && rcnt > 8));
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_taken;
    (avmm_req.read || avmm_req.write) && avmm_waitrequest;
  endsequence
  sequence s_ctrl_done;
    rs && avmm_req.address == ADDR_CTRL;
  endsequence
  a_bus_answer: assert property (s_taken |=> !avmm_waitrequest)
    else $error("request not answered");
  a_wait_single: assert property (!avmm_waitrequest |=> avmm_waitrequest)
    else $error("waitrequest low too long");
  a_chan_follow: assert property (s_ctrl_done |=> ##[0:1] channel_sel == chan)
    else $error("channel select wrong");
  a_swap_off: assert property (chop_dis && $past(chop_dis, 4) |-> !input_swap)
    else $error("swap while chop off");
  a_strobe_period: assert property (result_strobe && seen |-> scnt == per)
    else $error("result spacing wrong");
  a_settle_first: assert property (result_strobe && !seen |->
    rcnt inside {[base - 2 * TP : base + 2 * TP + 8]}) else $error("first result early");
  a_settle_bound: assert property (!seen |-> rcnt <= base + 2 * TP + 8)
    else $error("first result late");
  a_swap_period: assert property (swchg && sseen && !chop_dis |-> wcnt == per)
    else $error("swap spacing wrong");
endmodule : sinc3_checker

bind sinc3_decimator_chop_ctrl sinc3_checker #(.MOD_TICK_P(MOD_TICK_P)) u_checker (
  .sys_clk(sys_clk), .arst_n(arst_n), .avmm_req(avmm_req),
  .avmm_waitrequest(avmm_waitrequest), .input_swap(input_swap),
  .channel_sel(channel_sel), .result_strobe(result_strobe));
`default_nettype wire

/* File: sim/mod_source.sv */
// Modulator stand-in: a steady input level seen through the chop reversal.
// Assumes the design synchronises mod_bit itself.
`default_nettype none
module mod_source (
  // Clock
  input wire logic sys_clk,
  // Control
  input wire logic level_high,
  input wire logic input_swap,
  // Bit stream
  output logic mod_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level carries no offset or drift, so no recalibration is owed
  // Reversed inputs invert the stream
  always_ff @(posedge sys_clk) mod_bit <= level_high ^ input_swap;
endmodule : mod_source
`default_nettype wire

/* File: sim/test_sinc3_decimator_chop_ctrl.sv */
// Bench for the sinc3 decimator: bus tasks, queued read checks, decimation sweeps with chop off.
// Assumes a steady modulator level gives the full-scale sinc3 value.
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module test_sinc3_decimator_chop_ctrl
  import sinc3_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [31:0] m;} exp_t;
  exp_t q[$];
  exp_t cur;
  avmm_req_t req = '0;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic lvl = 1'b1;
  logic [31:0] rdata;
  logic wreq, mbit, swap, strobe;
  logic [CHAN_W-1:0] chan;
  logic [3:0] ch;
  int n_errors = 0;
  int checks = 0;
  int d;
  int dl[4] = '{3, 255, 0, 0};
  always #2 sys_clk = ~sys_clk;
  sinc3_decimator_chop_ctrl #(.MOD_TICK_P(4)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
    .avmm_req(req), .avmm_readdata(rdata), .avmm_waitrequest(wreq), .mod_bit(mbit),
    .input_swap(swap), .channel_sel(chan), .result_strobe(strobe));
  mod_source u_src (.sys_clk(sys_clk), .level_high(lvl), .input_swap(swap),
    .mod_bit(mbit));
  function automatic logic [31:0] full(input int dw, input logic hi);
    longint m;
    m = 8 * dw;
    m = m * m * m;
    return 32'(hi ? m >>> 3 : -m >>> 3);
  endfunction : full
  task automatic test_done();
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic bus(input logic [2:0] a, input logic w, input logic [31:0] v,
                     input logic [3:0] be);
    int i;
    @(posedge sys_clk);
    req <= '{address: a, read: !w, write: w, writedata: v, byteenable: be};
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (wreq !== 1'b0 && i < 50);
    if (i >= 50) begin
      n_errors++;
      test_done();
    end
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [31:0] v);
    bus(a, 1'b1, v, 4'h1);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{d: e, m: m});
    bus(a, 1'b0, 32'h0000_0000, 4'hf);
  endtask : rd
  task automatic strobes(input int n);
    int i;
    i = 0;
    while (n > 0 && i < 60000) begin
      @(posedge sys_clk);
      i++;
      if (strobe === 1'b1) n--;
    end
    if (n > 0) begin
      n_errors++;
      test_done();
    end
  endtask : strobes
  always @(posedge sys_clk) begin
    if (req.read && wreq === 1'b0 && q.size() > 0) begin
      cur = q.pop_front();
      `CHK(rdata & cur.m, cur.d & cur.m)
    end
  end
  initial begin
    void'($urandom(26));
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(ADDR_DECIM, 32'h0000_0045, 32'h0000_00ff);
    rd(ADDR_CTRL, 32'h0000_0000, 32'h0000_0001);
    bus(ADDR_DECIM, 1'b1, 32'h0000_0007, 4'he);
    rd(ADDR_DECIM, 32'h0000_0045, 32'h0000_00ff);
    bus(3'h7, 1'b1, 32'h0000_0011, 4'hf);
    rd(3'h7, 32'h0000_0000, '1);
    strobes(1);
    rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    rd(ADDR_DATA, full(int'(DECIM_RESET), 1'b1), '1);
    rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0001);
    strobes(1);
    wr(ADDR_DECIM, 32'h0000_000d);
    strobes(2);
    rd(ADDR_DATA, full(13, 1'b1), '1);
    dl[2] = int'(3 + $urandom % 20);
    dl[3] = int'(3 + $urandom % 20);
    foreach (dl[k]) begin
      d = dl[k];
      ch = 4'($urandom);
      lvl <= 1'(k % 2);
      wr(ADDR_CTRL, {24'h00_0000, ch, 4'h1});
      wr(ADDR_DECIM, 32'(d));
      strobes(1);
      `CHK(chan, ch)
      rd(ADDR_DATA, full(d, 1'(k % 2)), '1);
      strobes(1);
    end
    repeat (1 + $urandom % 90) @(posedge sys_clk);
    lvl <= 1'b0;
    // Results in between are not settled and stay unread
    strobes(4);
    rd(ADDR_DATA, full(d, 1'b0), '1);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(ADDR_DECIM, 32'h0000_0045, 32'h0000_00ff);
    rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_001f);
    rd(ADDR_COUNT, 32'h0000_0000, 32'h0000_ffff);
    test_done();
  end
endmodule : test_sinc3_decimator_chop_ctrl
`default_nettype wire
